// ### include/emu_mem_ctrl_pkg.sv
// constants, encodings and carriers shared by the emulation memory map controller
`default_nettype none

package emu_mem_ctrl_pkg;

	// clock and memory geometry
	localparam int unsigned CLOCK_HZ        = 100_000_000;
	localparam int unsigned BANK_KBYTES     = 8;
	localparam int unsigned PAGE_KBYTES     = 16;
	localparam int unsigned PAGE_COUNT      = 64;
	localparam int unsigned PAGE_BITS       = 6;
	localparam int unsigned PAGE_OFFS_BITS  = 14;
	localparam int unsigned ADDR_BITS       = 20;
	localparam int unsigned LOW_ADDR_BITS   = 7;
	localparam int unsigned MAP_ADDR_BITS   = 13;
	localparam int unsigned MAP_DATA_BITS   = 9;
	localparam int unsigned BLOCK_BITS      = 6;
	localparam int unsigned PASS_BITS       = MAP_ADDR_BITS - BLOCK_BITS;
	localparam int unsigned HOST_DATA_BITS  = 16;
	localparam int unsigned IDENT_BIT       = 9;

	// one-of-eight function codes on the function select lines
	localparam logic [2:0] FN_HOST_ACCESS   = 3'h1;
	localparam logic [2:0] FN_MAPPER_LOAD   = 3'h2;
	localparam logic [2:0] FN_PAGE_LOAD     = 3'h3;
	localparam logic [2:0] FN_IDENT         = 3'h4;

	// register map, byte addresses of 32-bit words
	localparam int unsigned AV_ADDR_BITS    = 4;
	localparam logic [3:0] REG_CONTROL      = 4'h0;
	localparam logic [3:0] REG_STATUS       = 4'h4;
	localparam logic [3:0] REG_IDENT        = 4'h8;

	// control and status field positions
	localparam int unsigned CTRL_ILLEGAL_EN = 0;
	localparam int unsigned STAT_BREAK      = 0;
	localparam int unsigned STAT_HOST_FLAG  = 1;
	localparam int unsigned STAT_PAGE_LSB   = 8;

	// reset values
	localparam logic        RESET_ILLEGAL_EN = 1'b0;
	localparam logic [5:0]  RESET_PAGE       = 6'h00;
	localparam logic [31:0] IDENT_VALUE      = 32'h00C0_FFEE; // arbitrary value

	// one mapper word as the host writes it
	typedef struct packed {
		logic                  guard;
		logic                  rom;
		logic                  user;
		logic [BLOCK_BITS-1:0] block;
	} map_entry_s;

	// emulator side memory request
	typedef struct packed {
		logic [ADDR_BITS-1:0] address;
		logic                 write;
		logic                 write_strobe;
		logic                 upper_byte;
		logic                 byte_mode;
		logic                 cycle_start;
		logic                 busy;
	} emu_req_s;

	// host side pin group
	typedef struct packed {
		logic [2:0]                function_select_lines;
		logic                      board_select;
		logic                      host_strobe;
		logic                      host_write;
		logic                      host_upper_byte;
		logic                      host_byte_mode;
		logic                      host_poll;
		logic [PAGE_OFFS_BITS-1:0] address;
		logic [HOST_DATA_BITS-1:0] host_data_bus;
	} host_req_s;

endpackage

`default_nettype wire

// ### logic/emulation_memory_map_control.sv
// emulation memory map controller: function decode, pager, mapper, strobes, break and register slave
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`default_nettype none

module emulation_memory_map_control #(
	parameter int unsigned MAP_DEPTH = 2 ** emu_mem_ctrl_pkg::MAP_ADDR_BITS
) (
	// clock and reset
	input  wire logic                                          i_clock,
	input  wire logic                                          i_nrst,
	// host mainframe pins
	input  wire emu_mem_ctrl_pkg::host_req_s                   i_host,
	output logic                                               o_ident_data_out,
	output logic                                               o_ident_data_oe,
	// emulator bus
	input  wire emu_mem_ctrl_pkg::emu_req_s                    i_emu,
	output logic                                               o_break,
	// memory boards
	output logic [emu_mem_ctrl_pkg::ADDR_BITS-1:0]             o_mem_address,
	output logic                                               o_upper_byte_strobe,
	output logic                                               o_lower_byte_strobe,
	output logic                                               o_board_buffer_direction,
	output logic                                               o_user_memory,
	// avalon-mm register slave
	input  wire logic [emu_mem_ctrl_pkg::AV_ADDR_BITS-1:0]     i_avs_address,
	input  wire logic                                          i_avs_read,
	input  wire logic                                          i_avs_write,
	input  wire logic [31:0]                                   i_avs_writedata,
	input  wire logic [3:0]                                    i_avs_byteenable,
	output logic [31:0]                                        o_avs_readdata,
	output logic                                               o_avs_waitrequest
);

	// function decoder
	logic [7:0]                                  fn_decode;
	logic                                        fn_active;
	logic                                        mapper_load_fn;
	logic                                        page_load_fn;
	logic                                        host_memory_access_fn;
	logic                                        ident_enable_fn;
	logic                                        host_write_qualified;
	logic                                        break_clear;

	// pager, access control and address mux
	logic [emu_mem_ctrl_pkg::PAGE_BITS-1:0]      page;
	logic                                        page_load_write;
	logic                                        page_load_write_q;
	logic                                        host_access_flag;
	logic                                        next_host_access_flag;
	logic [emu_mem_ctrl_pkg::ADDR_BITS-1:0]      host_address;
	logic [emu_mem_ctrl_pkg::ADDR_BITS-1:0]      mux_address;
	logic [emu_mem_ctrl_pkg::MAP_ADDR_BITS-1:0]  map_index;

	// mapper
	emu_mem_ctrl_pkg::map_entry_s                mapper [MAP_DEPTH];
	emu_mem_ctrl_pkg::map_entry_s                map_out;
	emu_mem_ctrl_pkg::map_entry_s                map_wdata;
	logic                                        mapper_write;

	// illegal access and strobes
	logic                                        illegal_en;
	logic                                        illegal_access;
	logic                                        emu_blocked;
	logic                                        break_flag;
	logic                                        next_upper;
	logic                                        next_lower;
	logic                                        next_direction;

	// register slave
	logic                                        av_req;
	logic                                        av_ack;
	logic [31:0]                                 next_readdata;

	// ------------------------------------------------------------------
	// function select
	// ------------------------------------------------------------------

	// board select and strobe are plain levels; the host holds them for a whole function
	// functions only exist while the host holds board select and strobe
	assign fn_active = i_host.board_select & i_host.host_strobe;

	generate
		for (genvar code = 0; code < 8; code++) begin : g_decode
			assign fn_decode[code] = fn_active & (i_host.function_select_lines == 3'(code));
		end
	endgenerate

	// the remaining four decoder outputs go nowhere
	// a stray code therefore selects nothing and leaves the memory alone
	assign host_memory_access_fn = fn_decode[emu_mem_ctrl_pkg::FN_HOST_ACCESS];
	assign mapper_load_fn        = fn_decode[emu_mem_ctrl_pkg::FN_MAPPER_LOAD];
	assign page_load_fn          = fn_decode[emu_mem_ctrl_pkg::FN_PAGE_LOAD];
	assign ident_enable_fn       = fn_decode[emu_mem_ctrl_pkg::FN_IDENT];

	assign host_write_qualified  = host_memory_access_fn & i_host.host_write;
	assign break_clear           = ident_enable_fn & i_host.host_poll;

	// ------------------------------------------------------------------
	// identification: open-collector low on host data bit nine
	// ------------------------------------------------------------------

	// the pin is only ever pulled low; the host bus pull-up gives the high level
	// the same poll that identifies the board also clears a pending break
	assign o_ident_data_out = 1'b0;
	assign o_ident_data_oe  = break_clear;

	// ------------------------------------------------------------------
	// page latch
	// ------------------------------------------------------------------

	// the combined select and write is delayed one clock to find its leading edge
	assign page_load_write = page_load_fn & i_host.host_write;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			page_load_write_q <= 1'b0;
		end else begin
			page_load_write_q <= page_load_write;
		end
	end

	// loads once per host write, on its leading edge, so a held strobe does not re-latch
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			page <= emu_mem_ctrl_pkg::RESET_PAGE;
		end else if (page_load_write && !page_load_write_q) begin
			page <= i_host.host_data_bus[emu_mem_ctrl_pkg::PAGE_BITS-1:0];
		end
	end

	// ------------------------------------------------------------------
	// access control
	// ------------------------------------------------------------------

	// the host waits for the emulator to leave its memory cycle before it takes over
	// a mapper load needs the mux as well, so it takes the same grant as a host access
	// the grant drops as soon as the function goes away, handing memory back to the emulator
	// limitation: a host that holds its function forever starves the emulator
	always_comb begin
		next_host_access_flag = host_access_flag;
		if (!(host_memory_access_fn || mapper_load_fn)) begin
			next_host_access_flag = 1'b0;
		end else if (!i_emu.busy) begin
			next_host_access_flag = 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			host_access_flag <= 1'b0;
		end else begin
			host_access_flag <= next_host_access_flag;
		end
	end

	// ------------------------------------------------------------------
	// address multiplexer
	// ------------------------------------------------------------------

	// the page supplies the bits above the host offset, so one page spans the host window
	assign host_address = {page, i_host.address};
	assign mux_address  = host_access_flag ? host_address : i_emu.address;
	assign map_index    = mux_address[emu_mem_ctrl_pkg::ADDR_BITS-1:emu_mem_ctrl_pkg::LOW_ADDR_BITS];

	// ------------------------------------------------------------------
	// mapper
	// ------------------------------------------------------------------

	assign map_wdata    = emu_mem_ctrl_pkg::map_entry_s'(i_host.host_data_bus[emu_mem_ctrl_pkg::MAP_DATA_BITS-1:0]);
	// writes only once the host owns the address mux, so the entry lands at the host address
	assign mapper_write = mapper_load_fn & i_host.host_write & host_access_flag;

	// one index serves writes and reads, so a load reads back the entry being written
	// leaving the array without reset lets it map onto a block memory
	// no reset: contents are meaningless until the host programs them
	always_ff @(posedge i_clock) begin
		if (mapper_write) begin
			mapper[map_index] <= map_wdata;
		end
	end

	// read port; registered so the translated address comes from flip-flops
	always_ff @(posedge i_clock) begin
		map_out <= mapper[map_index];
	end

	// ------------------------------------------------------------------
	// memory address out
	// ------------------------------------------------------------------

	// block bits are stored as written and driven out complemented; the rest of the upper field passes through
	// only six block bits are stored, so mux bits 13:7 bypass the mapper
	// the upper bits trail the mux by two clocks, the rest by one
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_mem_address <= '0;
		end else begin
			o_mem_address[emu_mem_ctrl_pkg::LOW_ADDR_BITS-1:0] <=
				mux_address[emu_mem_ctrl_pkg::LOW_ADDR_BITS-1:0];
			o_mem_address[emu_mem_ctrl_pkg::LOW_ADDR_BITS+emu_mem_ctrl_pkg::PASS_BITS-1:
				emu_mem_ctrl_pkg::LOW_ADDR_BITS] <=
				map_index[emu_mem_ctrl_pkg::PASS_BITS-1:0];
			o_mem_address[emu_mem_ctrl_pkg::ADDR_BITS-1:emu_mem_ctrl_pkg::ADDR_BITS-emu_mem_ctrl_pkg::BLOCK_BITS] <=
				~map_out.block;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_user_memory <= 1'b0;
		end else begin
			// user blocks live in the target system, so a host access never flags them
			o_user_memory <= map_out.user & !host_access_flag;
		end
	end

	// ------------------------------------------------------------------
	// illegal access and break
	// ------------------------------------------------------------------

	assign illegal_access = illegal_en & ((map_out.rom & i_emu.write) | map_out.guard);
	// a user block is not illegal, but the boards must still stay off the bus for it
	assign emu_blocked    = illegal_access | map_out.user;

	// sampled at the start of each emulator cycle only; a clear in the same cycle loses
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			break_flag <= 1'b0;
		end else if (i_emu.cycle_start && !host_access_flag && illegal_access) begin
			break_flag <= 1'b1;
		end else if (break_clear) begin
			break_flag <= 1'b0;
		end
	end

	assign o_break = break_flag;

	// ------------------------------------------------------------------
	// write strobes and buffer direction
	// ------------------------------------------------------------------

	// both terms are gated by the grant, so host and emulator strobes never overlap
	// registered strobes trail the request by one clock, which keeps them free of glitches
	always_comb begin
		next_upper = (host_access_flag & host_write_qualified & i_host.host_upper_byte)
			| (i_emu.upper_byte & i_emu.write_strobe & !host_access_flag & !emu_blocked);
		next_lower = (host_access_flag & host_write_qualified
				& (!i_host.host_byte_mode | !i_host.host_upper_byte))
			| (i_emu.write_strobe & (i_emu.upper_byte | i_emu.byte_mode)
				& !host_access_flag & !emu_blocked);
		next_direction = host_access_flag ? i_host.host_write : i_emu.write;
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_upper_byte_strobe      <= 1'b0;
			o_lower_byte_strobe      <= 1'b0;
			o_board_buffer_direction <= 1'b0;
		end else begin
			o_upper_byte_strobe      <= next_upper;
			o_lower_byte_strobe      <= next_lower;
			o_board_buffer_direction <= next_direction;
		end
	end

	// ------------------------------------------------------------------
	// avalon-mm slave: one wait state on every access
	// ------------------------------------------------------------------

	// waitrequest is combinational so the master sees it in the cycle of its request
	// the acknowledge lasts one clock, so a request that stays up waits again
	assign av_req            = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = av_req & !av_ack;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			av_ack <= 1'b0;
		end else begin
			av_ack <= av_req & !av_ack;
		end
	end

	// the set/clear illegal control lives here even though the decoder leaves four codes free
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			illegal_en <= emu_mem_ctrl_pkg::RESET_ILLEGAL_EN;
		end else if (i_avs_write && av_ack && i_avs_byteenable[0]
				&& i_avs_address == emu_mem_ctrl_pkg::REG_CONTROL) begin
			illegal_en <= i_avs_writedata[emu_mem_ctrl_pkg::CTRL_ILLEGAL_EN];
		end
	end

	always_comb begin
		next_readdata = '0;
		unique case (i_avs_address)
			emu_mem_ctrl_pkg::REG_CONTROL: begin
				next_readdata[emu_mem_ctrl_pkg::CTRL_ILLEGAL_EN] = illegal_en;
			end
			emu_mem_ctrl_pkg::REG_STATUS: begin
				next_readdata[emu_mem_ctrl_pkg::STAT_BREAK]     = break_flag;
				next_readdata[emu_mem_ctrl_pkg::STAT_HOST_FLAG] = host_access_flag;
				next_readdata[emu_mem_ctrl_pkg::STAT_PAGE_LSB+emu_mem_ctrl_pkg::PAGE_BITS-1:
					emu_mem_ctrl_pkg::STAT_PAGE_LSB] = page;
			end
			emu_mem_ctrl_pkg::REG_IDENT: begin
				next_readdata = emu_mem_ctrl_pkg::IDENT_VALUE;
			end
			default: begin
				next_readdata = '0;
			end
		endcase
	end

	// captured in the wait cycle so the data stand at the edge where waitrequest is low
	// a status read shows the break and grant as they were one clock before the answer
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_avs_readdata <= '0;
		end else if (i_avs_read && !av_ack) begin
			o_avs_readdata <= next_readdata;
		end
	end

endmodule // emulation_memory_map_control

`default_nettype wire

// ### verif/emu_bus_model.sv
// emulator bus model: one memory cycle per request, address leads cycle start by one clock
`default_nettype none

module emu_bus_model (
	// clock and reset
	input  wire logic                      i_clock,
	input  wire logic                      i_nrst,
	// commands from the bench
	input  wire logic                      i_go,
	input  wire logic [19:0]               i_address,
	input  wire logic                      i_write,
	input  wire logic                      i_upper,
	input  wire logic                      i_byte,
	// emulator bus
	output emu_mem_ctrl_pkg::emu_req_s     o_emu
);
	logic [1:0] phase;

	// the cycle start waits one clock so the mapper entry behind the address has settled
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			phase <= 2'h0;
			o_emu <= '0;
		end else if (i_go) begin
			phase <= (phase == 2'h2) ? 2'h2 : phase + 2'h1;
			o_emu.address <= i_address;
			o_emu.cycle_start <= phase == 2'h1;
			o_emu.busy <= phase != 2'h0;
			o_emu.write <= i_write && phase != 2'h0;
			o_emu.write_strobe <= i_write && phase != 2'h0;
			o_emu.upper_byte <= i_upper;
			o_emu.byte_mode <= i_byte;
		end else begin
			phase <= 2'h0;
			// idle bus shows the inverse of the last address, everything else low
			o_emu <= {~o_emu.address, 6'h00};
		end
	end
endmodule // emu_bus_model

`default_nettype wire

// ### verif/emulation_memory_map_control_monitor.sv
// port-level assertions for the emulation memory map controller
`default_nettype none

module emulation_memory_map_control_checker #(
	parameter int unsigned MAP_DEPTH = 8192
) (
	input wire logic                                    i_clock,
	input wire logic                                    i_nrst,
	input wire emu_mem_ctrl_pkg::host_req_s             i_host,
	input wire emu_mem_ctrl_pkg::emu_req_s              i_emu,
	input wire logic                                    o_ident_data_out,
	input wire logic                                    o_ident_data_oe,
	input wire logic                                    o_break,
	input wire logic [emu_mem_ctrl_pkg::ADDR_BITS-1:0]  o_mem_address,
	input wire logic                                    o_upper_byte_strobe,
	input wire logic                                    o_lower_byte_strobe,
	input wire logic                                    o_board_buffer_direction
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	logic sel, id, hw;
	assign sel = i_host.board_select && i_host.host_strobe;
	assign id = sel && i_host.function_select_lines == emu_mem_ctrl_pkg::FN_IDENT && i_host.host_poll;
	assign hw = sel && i_host.function_select_lines == emu_mem_ctrl_pkg::FN_HOST_ACCESS && !i_emu.busy;

	property p_ident_pull;
		id |-> o_ident_data_oe && !o_ident_data_out;
	endproperty
	a_ident_pull: assert property (p_ident_pull) else $error("ident pull missing");
	property p_break_clear;
		id && !i_emu.cycle_start |=> ##[0:1] !o_break;
	endproperty
	a_break_clear: assert property (p_break_clear) else $error("break not cleared by poll");
	property p_break_hold;
		o_break && !id && !$past(id) |=> o_break;
	endproperty
	a_break_hold: assert property (p_break_hold) else $error("break dropped without poll");
	property p_reset_quiet;
		$rose(i_nrst) |-> !o_upper_byte_strobe && !o_lower_byte_strobe && !o_break;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
	property p_dir;
		o_upper_byte_strobe || o_lower_byte_strobe |-> o_board_buffer_direction;
	endproperty
	a_dir: assert property (p_dir) else $error("strobe without write direction");
	property p_emu_addr;
		(!sel && $stable(i_emu.address))[*5] |-> o_mem_address[13:0] == i_emu.address[13:0];
	endproperty
	a_emu_addr: assert property (p_emu_addr) else $error("emulator low address not passed");
	property p_host_addr;
		(hw && $stable(i_host.address))[*5] |-> o_mem_address[13:0] == i_host.address;
	endproperty
	a_host_addr: assert property (p_host_addr) else $error("host address not selected");
	property p_upper;
		(hw && $stable(i_host))[*5] |-> o_upper_byte_strobe == (i_host.host_write && i_host.host_upper_byte);
	endproperty
	a_upper: assert property (p_upper) else $error("host upper strobe wrong");
	property p_lower;
		(hw && $stable(i_host))[*5] |->
			o_lower_byte_strobe == (i_host.host_write && !(i_host.host_byte_mode && i_host.host_upper_byte));
	endproperty
	a_lower: assert property (p_lower) else $error("host lower strobe wrong");
endmodule // emulation_memory_map_control_checker

bind emulation_memory_map_control emulation_memory_map_control_checker #(.MAP_DEPTH(MAP_DEPTH)) u_checker (
	.i_clock(i_clock), .i_nrst(i_nrst), .i_host(i_host), .i_emu(i_emu),
	.o_ident_data_out(o_ident_data_out), .o_ident_data_oe(o_ident_data_oe), .o_break(o_break),
	.o_mem_address(o_mem_address), .o_upper_byte_strobe(o_upper_byte_strobe),
	.o_lower_byte_strobe(o_lower_byte_strobe), .o_board_buffer_direction(o_board_buffer_direction)
);

`default_nettype wire

// ### verif/emulation_memory_map_control_test.sv
// self-checking bench for the emulation memory map controller
`default_nettype none

module emulation_memory_map_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0;
	logic i_nrst = 1'b0;
	emu_mem_ctrl_pkg::host_req_s host = '0;
	emu_mem_ctrl_pkg::host_req_s host_in;
	emu_mem_ctrl_pkg::emu_req_s emu;
	logic go = 1'b0, ew = 1'b0, eu = 1'b0, eb = 1'b0, ard = 1'b0, awr = 1'b0;
	logic [19:0] ea = 20'h00000;
	logic [3:0] aa = 4'h0;
	logic [31:0] awd = 32'h00000000, rdata, rd;
	logic oe, odo, brk, ub, lb, dir, usr, wreq, w, u, b;
	logic [19:0] ma;
	logic [12:0] idx;
	logic [8:0] ent;
	logic [6:0] lo;
	logic [1:0] kd;
	int n_mismatch = 0, num_checks = 0, seed = 8;

	always #5 i_clock = ~i_clock;
	// the device pulls data bit nine low while it drives it
	always_comb begin
		host_in = host;
		if (oe)
			host_in.host_data_bus[9] = odo;
	end

	emulation_memory_map_control #(.MAP_DEPTH(8192)) dut (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_host(host_in), .o_ident_data_out(odo), .o_ident_data_oe(oe),
		.i_emu(emu), .o_break(brk), .o_mem_address(ma), .o_upper_byte_strobe(ub), .o_lower_byte_strobe(lb),
		.o_board_buffer_direction(dir), .o_user_memory(usr), .i_avs_address(aa), .i_avs_read(ard),
		.i_avs_write(awr), .i_avs_writedata(awd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq));
	emu_bus_model partner (.i_clock(i_clock), .i_nrst(i_nrst), .i_go(go), .i_address(ea), .i_write(ew),
		.i_upper(eu), .i_byte(eb), .o_emu(emu));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// the request stands until waitrequest is seen low at a rising edge
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clock);
		aa <= a;
		awd <= d;
		ard <= !wr;
		awr <= wr;
		do begin
			@(posedge i_clock);
		end while (wreq !== 1'b0);
		rd = rdata;
		ard <= 1'b0;
		awr <= 1'b0;
	endtask
	task automatic hon(input logic [2:0] f, input logic wr, input logic [15:0] d, input logic [13:0] a,
		input logic [2:0] m);
		@(posedge i_clock);
		host.function_select_lines <= f;
		host.board_select <= 1'b1;
		host.host_strobe <= 1'b1;
		host.host_write <= wr;
		host.host_data_bus <= d;
		host.address <= a;
		{host.host_poll, host.host_upper_byte, host.host_byte_mode} <= m;
	endtask
	task automatic hoff;
		@(posedge i_clock);
		host.board_select <= 1'b0;
		host.host_strobe <= 1'b0;
		host.host_write <= 1'b0;
		host.host_poll <= 1'b0;
		host.host_data_bus <= ~host.host_data_bus;
	endtask
	task automatic map_wr(input logic [12:0] i, input logic [8:0] e);
		hon(emu_mem_ctrl_pkg::FN_PAGE_LOAD, 1'b1, {10'h000, i[12:7]}, 14'h0000, 3'h0);
		hoff;
		hon(emu_mem_ctrl_pkg::FN_MAPPER_LOAD, 1'b1, {7'h00, e}, {i[6:0], 7'h00}, 3'h0);
		repeat (3) @(posedge i_clock);
		hoff;
	endtask
	task automatic emu_cyc(input logic [19:0] a, input logic wr, input logic up, input logic by);
		@(posedge i_clock);
		go <= 1'b1;
		ea <= a;
		ew <= wr;
		eu <= up;
		eb <= by;
		repeat (5) @(posedge i_clock);
		@(negedge i_clock);
	endtask
	task automatic emu_end;
		@(posedge i_clock);
		go <= 1'b0;
	endtask
	task automatic test_done;
		if (n_mismatch == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#200000;
		n_mismatch++;
		test_done;
	end

	initial begin
		repeat (6) @(posedge i_clock);
		i_nrst <= 1'b1;
		@(negedge i_clock);
		chk("quiet after reset", 32'h0, {ub, lb, brk});
		av(1'b0, emu_mem_ctrl_pkg::REG_IDENT, 32'h0);
		chk("ident register", emu_mem_ctrl_pkg::IDENT_VALUE, rd);
		av(1'b0, 4'hC, 32'h0);
		chk("unmapped read", 32'h0, rd);
		av(1'b1, emu_mem_ctrl_pkg::REG_CONTROL, 32'h1);
		av(1'b0, emu_mem_ctrl_pkg::REG_CONTROL, 32'h0);
		chk("illegal enable", 32'h1, rd);
		// holding the load with new data must not reload the page
		hon(emu_mem_ctrl_pkg::FN_PAGE_LOAD, 1'b1, 16'h0015, 14'h0000, 3'h0);
		@(posedge i_clock);
		host.host_data_bus <= 16'h002A;
		hoff;
		av(1'b0, emu_mem_ctrl_pkg::REG_STATUS, 32'h0);
		chk("page latch edge", 32'h15, {26'h0, rd[13:8]});
		for (int k = 0; k < 8; k++) begin
			kd = k[1:0];
			idx = 13'($random(seed));
			ent = {kd == 2'h3, kd == 2'h2, kd == 2'h1, 6'($random(seed))};
			lo = 7'($random(seed));
			{w, u, b} = 3'($random(seed));
			map_wr(idx, ent);
			av(1'b0, emu_mem_ctrl_pkg::REG_STATUS, 32'h0);
			chk("page", {26'h0, idx[12:7]}, {26'h0, rd[13:8]});
			hon(emu_mem_ctrl_pkg::FN_HOST_ACCESS, 1'b1, 16'h1234, {idx[6:0], lo}, {1'b0, u, b});
			repeat (5) @(posedge i_clock);
			@(negedge i_clock);
			chk("host address", {~ent[5:0], idx[6:0], lo}, ma);
			chk("host strobes", {u, !(u && b), 1'b1}, {ub, lb, dir});
			hoff;
			emu_cyc({idx, lo}, w, u, b);
			chk("emu address", {~ent[5:0], idx[6:0], lo}, ma);
			if (kd < 2'h2)
				chk("emu strobes", {w && kd == 2'h0 && u, w && kd == 2'h0 && (u || b)}, {ub, lb});
			chk("emu direction", w, dir);
			chk("user type", kd == 2'h1, usr);
			chk("break", kd == 2'h3 || (kd == 2'h2 && w), brk);
			emu_end;
			repeat (3) @(posedge i_clock);
			@(negedge i_clock);
			chk("break held", kd == 2'h3 || (kd == 2'h2 && w), brk);
			hon(emu_mem_ctrl_pkg::FN_IDENT, 1'b0, 16'h0200, 14'h0000, 3'h4);
			@(negedge i_clock);
			chk("ident bit", 32'h0, host_in.host_data_bus[9]);
			repeat (2) @(posedge i_clock);
			@(negedge i_clock);
			chk("break cleared", 32'h0, brk);
			hoff;
		end
		// host is held off while the emulator owns the memory
		emu_cyc({idx, lo}, 1'b0, 1'b0, 1'b0);
		hon(emu_mem_ctrl_pkg::FN_HOST_ACCESS, 1'b0, 16'h0000, 14'h0000, 3'h0);
		av(1'b0, emu_mem_ctrl_pkg::REG_STATUS, 32'h0);
		chk("flag while busy", 32'h0, rd[1]);
		emu_end;
		repeat (3) @(posedge i_clock);
		av(1'b0, emu_mem_ctrl_pkg::REG_STATUS, 32'h0);
		chk("flag when free", 32'h1, rd[1]);
		hoff;
		// the last mapped entry is guarded, so the busy test above left a break behind
		chk("break from guard", 32'h1, brk);
		hon(emu_mem_ctrl_pkg::FN_IDENT, 1'b0, 16'h0000, 14'h0000, 3'h4);
		hoff;
		av(1'b1, emu_mem_ctrl_pkg::REG_CONTROL, 32'h0);
		emu_cyc({idx, lo}, 1'b0, 1'b0, 1'b0);
		chk("guard disabled", 32'h0, brk);
		emu_end;
		test_done;
	end
endmodule // emulation_memory_map_control_test

`default_nettype wire
